/* sim/pad_model.sv */
// Pad model: board drive, pull-ups and floating level of one 8-bit port
`timescale 1ns/1ps
`default_nettype none
module pad_model (
   // Clock
   input wire logic clk,
   // Block side
   input wire logic [7:0] padOut,
   input wire logic [7:0] padOeN,
   input wire logic [7:0] padPullup,
   // Board side
   input wire logic [7:0] extVal,
   input wire logic [7:0] extEn,
   output logic [7:0] pad
);
   logic [7:0] wander_reg = 8'h55;
   // A released pad wanders, so a stale level never passes as valid
   always @(posedge clk) wander_reg <= ~wander_reg;
   // Block drive wins, then the board, then the pull-up
   always_comb
      for (int i = 0; i < 8; i++)
         pad[i] = !padOeN[i] ? padOut[i] : extEn[i] ? extVal[i] : padPullup[i] | wander_reg[i];
endmodule // pad_model
`default_nettype wire

/* sim/port_bc_checker.sv */
// Checker for the port B and C pad override outputs
`timescale 1ns/1ps
`default_nettype none
module port_bc_checker (
   // Clock and reset
   input wire clk, rst,
   // Controls
   input wire clock_output_fuse, ioClock, spi_enable_bit, spi_master_select, spiClockOut,
   input wire spiSlaveOut, spiMasterOut, global_pullup_disable, timer0CompareBEnable,
   input wire timer0_compare_b_out, test_port_enable, instr_reg_shifting, data_reg_shifting,
   input wire testDataOut, async_timer_select, two_wire_enable, twoWireDataOut,
   input wire twoWireClockOut, sleepInputGate, pinchange_group_b_enable, external_irq2_enable,
   input wire [7:0] portBValue, pinChangeMaskB,
   // Pad controls
   input wire [7:0] pinBOut, pinBOeN, pinBPullup, pinCOut, pinCOeN, pinCPullup, inputEnableB
);
   // ********************
   // Override checks
   // ********************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // SPI master mode owns B7..B4
   wire spiMaster = spi_enable_bit && spi_master_select;
   clk_out_a: assert property (clock_output_fuse |-> pinBOut[1] == ioClock && !pinBOeN[1])
      else $error("clock pin not driven");
   spi_dir_a: assert property (spiMaster |-> pinBOeN[7:4] == 4'hf)
      else $error("spi pins not inputs");
   spi_out_a: assert property (spiMaster |-> pinBOut[7:5] == {spiClockOut, spiSlaveOut, spiMasterOut})
      else $error("spi output values wrong");
   spi_pull_a: assert property (spiMaster |-> pinBPullup[7:4] == (portBValue[7:4] & {4{!global_pullup_disable}}))
      else $error("spi pull-ups wrong");
   cmp_out_a: assert property (timer0CompareBEnable |-> pinBOut[3] == timer0_compare_b_out)
      else $error("compare output wrong");
   test_pull_a: assert property (test_port_enable |-> pinCPullup[5:2] == 4'hf)
      else $error("test pull-ups off");
   test_dout_a: assert property (test_port_enable |-> pinCOut[4] == testDataOut && pinCOeN[4] == !(instr_reg_shifting || data_reg_shifting))
      else $error("test data out wrong");
   osc_pin_a: assert property (async_timer_select |-> pinCOeN[6] && !pinCPullup[6])
      else $error("oscillator pin driven");
   twi_out_a: assert property (two_wire_enable |-> pinCOut[1:0] == {twoWireDataOut, twoWireClockOut})
      else $error("two-wire outputs wrong");
   in_en_a: assert property (pinchange_group_b_enable && sleepInputGate |-> inputEnableB == (pinChangeMaskB | {5'h0, external_irq2_enable, 2'h0}))
      else $error("input enable wrong");
endmodule // port_bc_checker
`default_nettype wire

/* sim/tb_port_bc_override.sv */
// Self-checking bench for the port B and C override logic
`timescale 1ns/1ps
`default_nettype none
module tb_port_bc_override;
   // Stimulus
   logic clk = 0, rst = 1;
   logic [7:0] portBValue = 0, portBDir = 0, portCValue = 0, portCDir = 0, extB = 0, extBEn = 0;
   logic [7:0] pinChangeMaskB = 0, pinChangeMaskC = 0;
   logic global_pullup_disable = 0, pinchange_group_b_enable = 0, pinchange_group_c_enable = 0;
   logic sleepInputGate = 0, clock_output_fuse = 0, ioClock = 0, usart0SyncMode = 0;
   logic usart0ClockOut = 0, spi_enable_bit = 0, spi_master_select = 0, spiClockOut = 0;
   logic spiSlaveOut = 0, spiMasterOut = 0, timer0_compare_a_out = 0, timer0CompareAEnable = 0;
   logic timer0_compare_b_out = 0, timer0CompareBEnable = 0, external_irq2_enable = 0;
   logic async_timer_select = 0, external_clock_select = 0, test_port_enable = 0;
   logic instr_reg_shifting = 0, data_reg_shifting = 0, testDataOut = 0, two_wire_enable = 0;
   logic twoWireDataOut = 0, twoWireClockOut = 0;
   // Design outputs
   wire [7:0] pinBIn, pinCIn, pinBOut, pinBOeN, pinBPullup, pinCOut, pinCOeN, pinCPullup;
   wire [7:0] inputEnableB, inputEnableC, pinBSync, pinCSync;
   wire usart0ClockIn, timer0_count_in, timer1_count_in, external_irq2_in, spiClockIn;
   wire spiMasterIn, spiSlaveIn, spiSelectIn, twoWireDataIn, twoWireClockIn, testDataIn;
   wire testModeIn, testClockIn, comparator_pos_in, comparator_neg_in;
   wire timer_osc_in_pin, timer_osc_out_pin;
   int errors = 0, comparisons = 0, cycles = 0;
   // ********************
   // Structure
   // ********************
   port_bc_override i_dut (.*);
   pad_model i_padB (.clk(clk), .padOut(pinBOut), .padOeN(pinBOeN), .padPullup(pinBPullup),
      .extVal(extB), .extEn(extBEn), .pad(pinBIn));
   pad_model i_padC (.clk(clk), .padOut(pinCOut), .padOeN(pinCOeN), .padPullup(pinCPullup),
      .extVal(8'h00), .extEn(8'h00), .pad(pinCIn));
   // 40 MHz clock
   always #12.5 clk = ~clk;
   // Hang guard; the tests need well under a hundred cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 400) begin
         errors++;
         finish_test;
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Inputs always change 2 ns after a rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic t_clkout;
      rst = 1;
      clock_output_fuse = 1;
      for (int i = 0; i < 4; i++) begin
         ioClock = i[0];
         rst = i[1];
         step(1);
         chk(pinBOut[1], i[0]);
         chk(pinBOeN[1], 0);
      end
      // Leave reset released so the synchronisers run for later tests
      rst = 0;
      clock_output_fuse = 0;
      step(1);
      chk(pinBOeN[1], 1);
      $display("test clkout done");
   endtask
   task automatic t_spi;
      {spi_enable_bit, spi_master_select, portBDir, portBValue} = {2'b11, 16'hfff0};
      {spiClockOut, spiSlaveOut, spiMasterOut} = 3'b101;
      step(1);
      chk(pinBOeN[7:4], 8'h0f);
      chk(pinBPullup[7:4], 8'h0f);
      chk(pinBOut[7:5], 8'h05);
      global_pullup_disable = 1;
      step(1);
      chk(pinBPullup[7:4], 8'h00);
      spi_enable_bit = 0;
      step(1);
      chk({pinBOeN[7:4], pinBOut[7:4]}, 8'h0f);
      {global_pullup_disable, portBDir, portBValue} = 0;
      $display("test spi done");
   endtask
   task automatic t_sync;
      {extBEn, extB} = 16'hcdc5;
      step(1);
      chk({comparator_neg_in, comparator_pos_in}, 8'h01);
      step(2);
      chk(pinBSync & 8'hcd, 8'hc5);
      chk({spiMasterIn, spiClockIn, usart0ClockIn, timer0_count_in}, 8'h0d);
      usart0SyncMode = 1;
      step(1);
      chk(usart0ClockIn, 1);
      {extBEn, portBDir, usart0ClockOut} = {16'h0001, 1'b1};
      step(1);
      chk({pinBOeN[0], pinBOut[0]}, 8'h01);
      usart0SyncMode = 0;
      step(1);
      chk(pinBOut[0], 0);
      portBDir = 0;
      $display("test sync done");
   endtask
   task automatic t_inen;
      {sleepInputGate, pinchange_group_b_enable, external_irq2_enable} = 3'b111;
      {pinchange_group_c_enable, pinChangeMaskB, pinChangeMaskC} = {1'b1, 16'h8103};
      step(1);
      chk(inputEnableB, 8'h85);
      chk(inputEnableC, 8'h03);
      test_port_enable = 1;
      step(1);
      chk(inputEnableC, 8'h3f);
      {sleepInputGate, pinchange_group_b_enable, test_port_enable} = 0;
      $display("test inen done");
   endtask
   task automatic t_misc;
      {test_port_enable, instr_reg_shifting, testDataOut} = 3'b111;
      {timer0CompareBEnable, timer0_compare_b_out, portBDir} = {2'b11, 8'h08};
      step(1);
      chk(pinCPullup[5:2], 8'h0f);
      chk({pinCOeN[4], pinCOut[4], pinBOut[3]}, 8'h03);
      instr_reg_shifting = 0;
      step(1);
      chk(pinCOeN[4], 1);
      {test_port_enable, two_wire_enable, twoWireDataOut, async_timer_select} = 4'b0111;
      {portCValue, portCDir} = 16'h4303;
      step(1);
      chk({pinCOut[1:0], pinCPullup[1:0]}, 8'h0b);
      chk({pinCOeN[6], pinCPullup[6]}, 8'h02);
      $display("test misc done");
   endtask
   task automatic finish_test;
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Main sequence after a 3-cycle reset
   initial begin
      step(3);
      rst = 0;
      t_clkout;
      t_spi;
      t_sync;
      t_inen;
      t_misc;
      finish_test;
   end
endmodule // tb_port_bc_override
bind port_bc_override port_bc_checker i_chk (.*);
`default_nettype wire

/* src/port_bc_override.v */
// Alternate-function override logic for the two 8-bit ports B and C
//
// Operation
// - Clock fuse drives divided clock on B1
// - Divided clock keeps running through reset
// - B1 direction and value overrides follow fuse
// - B0 direction bit picks USART clock direction
// - USART clock pin only in synchronous mode
// - B7..B4 overrides from SPI enable and master
// - B7 SPI clock, B6 slave, B5 master out
// - MISO/MOSI combine master and slave paths
// - Port B input enable from pin-change, irq2
// - Timer compare outputs override B3 and B4
// - B3/B2 comparator, B1/B0 timer count inputs
// - Oscillator pins: C6 overridden by async timer select, C7 only with external clock select too
// - Test port holds C5..C2 pull-ups on
// - C4 drives test data out while shifting
// - C5..C2 input enable follows test port enable
// - Two-wire enable overrides C1 and C0
// - Port C input enable from pin-change mask
`timescale 1ns/1ps
`default_nettype none
`include "port_bc_override_regs.vh"

module port_bc_override (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Port registers
   input wire [7:0] portBValue,
   input wire [7:0] portBDir,
   input wire [7:0] portCValue,
   input wire [7:0] portCDir,
   input wire global_pullup_disable,
   // Pin-change configuration
   input wire [7:0] pinChangeMaskB,
   input wire [7:0] pinChangeMaskC,
   input wire pinchange_group_b_enable,
   input wire pinchange_group_c_enable,
   // Idle input gating from the sleep logic
   input wire sleepInputGate,
   // Fuse and clock output
   input wire clock_output_fuse,
   input wire ioClock,
   // USART0 clock
   input wire usart0SyncMode,
   input wire usart0ClockOut,
   // SPI
   input wire spi_enable_bit,
   input wire spi_master_select,
   input wire spiClockOut,
   input wire spiSlaveOut,
   input wire spiMasterOut,
   // Timer0 compare outputs
   input wire timer0_compare_a_out,
   input wire timer0CompareAEnable,
   input wire timer0_compare_b_out,
   input wire timer0CompareBEnable,
   // External interrupt 2
   input wire external_irq2_enable,
   // Timer oscillator
   input wire async_timer_select,
   input wire external_clock_select,
   // Test port
   input wire test_port_enable,
   input wire instr_reg_shifting,
   input wire data_reg_shifting,
   input wire testDataOut,
   // Two-wire interface
   input wire two_wire_enable,
   input wire twoWireDataOut,
   input wire twoWireClockOut,
   // Pins
   input wire [7:0] pinBIn,
   input wire [7:0] pinCIn,
   output wire [7:0] pinBOut,
   output wire [7:0] pinBOeN,
   output wire [7:0] pinBPullup,
   output wire [7:0] pinCOut,
   output wire [7:0] pinCOeN,
   output wire [7:0] pinCPullup,
   // Input enables seen by the pads
   output wire [7:0] inputEnableB,
   output wire [7:0] inputEnableC,
   // Synchronised pin values for the port and pin-change logic
   output wire [7:0] pinBSync,
   output wire [7:0] pinCSync,
   // Peripheral inputs
   output wire usart0ClockIn,
   output wire timer0_count_in,
   output wire timer1_count_in,
   output wire external_irq2_in,
   output wire spiClockIn,
   output wire spiMasterIn,
   output wire spiSlaveIn,
   output wire spiSelectIn,
   output wire twoWireDataIn,
   output wire twoWireClockIn,
   output wire testDataIn,
   output wire testModeIn,
   output wire testClockIn,
   // Analog paths, straight from the pads
   output wire comparator_pos_in,
   output wire comparator_neg_in,
   output wire timer_osc_in_pin,
   output wire timer_osc_out_pin
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   reg [7:0] syncB1_reg;
   reg [7:0] syncB2_reg;
   reg [7:0] syncC1_reg;
   reg [7:0] syncC2_reg;

   // Override terms, one bit per pin
   reg [7:0] pullupOeB;
   reg [7:0] pullupOvB;
   reg [7:0] dirOeB;
   reg [7:0] dirOvB;
   reg [7:0] outOeB;
   reg [7:0] outOvB;
   reg [7:0] dieOeB;
   reg [7:0] dieOvB;
   reg [7:0] pullupOeC;
   reg [7:0] pullupOvC;
   reg [7:0] dirOeC;
   reg [7:0] dirOvC;
   reg [7:0] outOeC;
   reg [7:0] outOvC;
   reg [7:0] dieOeC;
   reg [7:0] dieOvC;

   wire spiMaster;
   wire puEnable;
   wire [7:0] pcEnB;
   wire [7:0] pcEnC;
   wire [7:0] dirB;
   wire [7:0] dirC;
   wire [7:0] gatedB;
   wire [7:0] gatedC;

   // Two stages; first stage feeds nothing but the second
   always @(posedge clk) begin
      if (rst) begin
         syncB1_reg <= `SYNC_RESET;
         syncB2_reg <= `SYNC_RESET;
         syncC1_reg <= `SYNC_RESET;
         syncC2_reg <= `SYNC_RESET;
      end else begin
         syncB1_reg <= pinBIn;
         syncB2_reg <= syncB1_reg;
         syncC1_reg <= pinCIn;
         syncC2_reg <= syncC1_reg;
      end
   end

   // ****************************************
   // Shared terms
   // ****************************************
   assign spiMaster = spi_enable_bit & spi_master_select;
   // Pull-up override follows the port bit unless pull-ups are off globally
   assign puEnable = ~global_pullup_disable;
   assign pcEnB = pinChangeMaskB & {8{pinchange_group_b_enable}};
   assign pcEnC = pinChangeMaskC & {8{pinchange_group_c_enable}};

   // ****************************************
   // Port B override terms
   // ****************************************
   // Defaults leave a pin as plain port I/O
   always @* begin
      pullupOeB = 8'h00;
      pullupOvB = 8'h00;
      dirOeB = 8'h00;
      dirOvB = 8'h00;
      outOeB = 8'h00;
      outOvB = 8'h00;
      // SPI pins; direction forced to input in master mode
      pullupOeB[7:4] = {4{spiMaster}};
      pullupOvB[7:4] = portBValue[7:4] & {4{puEnable}};
      dirOeB[7:4] = {4{spiMaster}};
      dirOvB[7:4] = 4'h0;
      outOeB[7:5] = {3{spiMaster}};
      outOvB[`PB_SPI_CLK] = spiClockOut;
      outOvB[`PB_SPI_MISO] = spiSlaveOut;
      outOvB[`PB_SPI_MOSI] = spiMasterOut;
      // Timer compare outputs
      outOeB[`PB_SPI_SEL] = timer0CompareAEnable;
      outOvB[`PB_SPI_SEL] = timer0_compare_a_out;
      outOeB[`PB_CMP_NEG] = timer0CompareBEnable;
      outOvB[`PB_CMP_NEG] = timer0_compare_b_out;
      // Clock out is pure logic of the fuse, so reset cannot stop it
      dirOeB[`PB_CLK_OUT] = clock_output_fuse;
      dirOvB[`PB_CLK_OUT] = clock_output_fuse;
      outOeB[`PB_CLK_OUT] = clock_output_fuse;
      outOvB[`PB_CLK_OUT] = ioClock;
      // USART clock drives out only in sync mode with direction set
      outOeB[`PB_USART_CLK] = usart0SyncMode & portBDir[`PB_USART_CLK];
      outOvB[`PB_USART_CLK] = usart0ClockOut;
      // Digital input kept alive for pin-change and irq2
      dieOeB = pcEnB;
      dieOeB[`PB_CMP_POS] = pcEnB[`PB_CMP_POS] | external_irq2_enable;
      dieOvB = 8'hff;
   end

   // ****************************************
   // Port C override terms
   // ****************************************
   always @* begin
      pullupOeC = 8'h00;
      pullupOvC = 8'h00;
      dirOeC = 8'h00;
      dirOvC = 8'h00;
      outOeC = 8'h00;
      outOvC = 8'h00;
      dieOeC = pcEnC;
      dieOvC = 8'hff;
      // Timer oscillator pins; pull-up and direction values stay zero
      pullupOeC[`PC_OSC_OUT] = async_timer_select & external_clock_select;
      dirOeC[`PC_OSC_OUT] = async_timer_select & external_clock_select;
      pullupOeC[`PC_OSC_IN] = async_timer_select;
      dirOeC[`PC_OSC_IN] = async_timer_select;
      dieOeC[`PC_OSC_OUT] = (async_timer_select & external_clock_select)
         | pcEnC[`PC_OSC_OUT];
      dieOvC[`PC_OSC_OUT] = async_timer_select;
      dieOeC[`PC_OSC_IN] = async_timer_select | pcEnC[`PC_OSC_IN];
      dieOvC[`PC_OSC_IN] = external_clock_select | async_timer_select;
      // Test port pins keep pull-ups on
      pullupOeC[5:2] = {4{test_port_enable}};
      pullupOvC[5:2] = 4'hf;
      dirOeC[5:2] = {4{test_port_enable}};
      dirOvC[`PC_TEST_DOUT] = instr_reg_shifting | data_reg_shifting;
      outOeC[`PC_TEST_DOUT] = test_port_enable;
      outOvC[`PC_TEST_DOUT] = testDataOut;
      dieOeC[5:2] = {4{test_port_enable}} | pcEnC[5:2];
      dieOvC[5:2] = {4{test_port_enable}};
      // Two-wire pins
      pullupOeC[1:0] = {2{two_wire_enable}};
      pullupOvC[1:0] = portCValue[1:0] & {2{puEnable}};
      dirOeC[1:0] = {2{two_wire_enable}};
      outOeC[1:0] = {2{two_wire_enable}};
      outOvC[`PC_TWI_DATA] = twoWireDataOut;
      outOvC[`PC_TWI_CLK] = twoWireClockOut;
      dieOvC[1:0] = 2'h3;
   end

   // ****************************************
   // Pad control
   // ****************************************
   // Each attribute takes its override when enabled
   assign dirB = (dirOeB & dirOvB) | (~dirOeB & portBDir);
   assign dirC = (dirOeC & dirOvC) | (~dirOeC & portCDir);
   assign pinBOeN = ~dirB;
   assign pinCOeN = ~dirC;
   assign pinBOut = (outOeB & outOvB) | (~outOeB & portBValue);
   assign pinCOut = (outOeC & outOvC) | (~outOeC & portCValue);

   // Plain pull-up only on inputs with the port bit set
   assign pinBPullup = (pullupOeB & pullupOvB)
      | (~pullupOeB & portBValue & ~portBDir & {8{puEnable}});
   assign pinCPullup = (pullupOeC & pullupOvC)
      | (~pullupOeC & portCValue & ~portCDir & {8{puEnable}});

   // Idle gating blocks inputs unless an override keeps them live
   assign inputEnableB = (dieOeB & dieOvB) | (~dieOeB & {8{~sleepInputGate}});
   assign inputEnableC = (dieOeC & dieOvC) | (~dieOeC & {8{~sleepInputGate}});

   // ****************************************
   // Input routing
   // ****************************************
   // A disabled input reads as zero so no spurious edges reach the logic
   assign gatedB = syncB2_reg & inputEnableB;
   assign gatedC = syncC2_reg & inputEnableC;
   assign pinBSync = gatedB;
   assign pinCSync = gatedC;

   // Port B peripheral inputs
   assign usart0ClockIn = gatedB[`PB_USART_CLK] & usart0SyncMode;
   assign timer0_count_in = gatedB[`PB_USART_CLK];
   assign timer1_count_in = gatedB[`PB_CLK_OUT];
   assign external_irq2_in = gatedB[`PB_CMP_POS];
   assign spiSelectIn = gatedB[`PB_SPI_SEL];
   assign spiSlaveIn = gatedB[`PB_SPI_MOSI];
   assign spiMasterIn = gatedB[`PB_SPI_MISO];
   assign spiClockIn = gatedB[`PB_SPI_CLK];

   // Port C peripheral inputs
   assign twoWireClockIn = gatedC[`PC_TWI_CLK];
   assign twoWireDataIn = gatedC[`PC_TWI_DATA];
   assign testClockIn = gatedC[`PC_TEST_CLK];
   assign testModeIn = gatedC[`PC_TEST_MODE];
   assign testDataIn = gatedC[`PC_TEST_DIN];

   // Analog nodes bypass the synchronisers; they are not sampled
   assign comparator_neg_in = pinBIn[`PB_CMP_NEG];
   assign comparator_pos_in = pinBIn[`PB_CMP_POS];
   assign timer_osc_in_pin = pinCIn[`PC_OSC_IN];
   assign timer_osc_out_pin = pinCIn[`PC_OSC_OUT];

endmodule // port_bc_override

`default_nettype wire

/* src/port_bc_override_regs.vh */
// Bit positions and reset values for the port B and C override logic
`ifndef PORT_BC_OVERRIDE_REGS_VH
`define PORT_BC_OVERRIDE_REGS_VH

// ********************
// Port B pin positions
// ********************
`define PB_USART_CLK 0
`define PB_CLK_OUT 1
`define PB_CMP_POS 2
`define PB_CMP_NEG 3
`define PB_SPI_SEL 4
`define PB_SPI_MOSI 5
`define PB_SPI_MISO 6
`define PB_SPI_CLK 7

// ********************
// Port C pin positions
// ********************
`define PC_TWI_CLK 0
`define PC_TWI_DATA 1
`define PC_TEST_CLK 2
`define PC_TEST_MODE 3
`define PC_TEST_DOUT 4
`define PC_TEST_DIN 5
`define PC_OSC_IN 6
`define PC_OSC_OUT 7

// ********************
// Reset values
// ********************
`define SYNC_RESET 8'h00

`endif
